// >>> rtl/pci_seq.sv
// Class, four-pair and inrush sequencer for one two-channel port
`timescale 1ns/1ps
`default_nettype none
module pci_seq #(
	parameter int START_N = pci_pkg::START_CYC,
	parameter int CRST_N = pci_pkg::CRST_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic power_budget_strap_low,
	input wire logic power_budget_strap_high,
	input wire logic four_pair_permit_n,
	input wire logic single_sig,
	input wire logic [1:0] det_ok,
	input wire logic [1:0] cls_done,
	input wire logic [5:0] cls_sig,
	input wire logic [1:0] over_inrush,
	input wire logic [8:0] avg_power,
	output logic [1:0] gate_en,
	output logic [1:0] gate_servo,
	output logic [1:0] cls_go,
	output logic [1:0] cls_hold_low,
	output logic [1:0] chan_powered,
	output logic [7:0] port_current_limit_code,
	output logic [3:0] port_class
);
	import pci_pkg::*;
	// Timer loads are 22 bits wide
	if (START_N < 1 || START_N > 4194303 || CRST_N < 1 || CRST_N > 4194303) begin : g_bad_n
		$error("Timer counts out of range");
	end
	// Pin inputs pass two flops; first stage read only by second
	logic [24:0] s1_r, s2_r;
	logic [1:0] dn_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_r <= '0;
			s2_r <= '0;
			dn_r <= '0;
		end else begin
			s1_r <= {avg_power, over_inrush, cls_sig, cls_done, det_ok,
				single_sig, four_pair_permit_n,
				power_budget_strap_high, power_budget_strap_low};
			s2_r <= s1_r;
			dn_r <= s2_r[7:6];
		end
	end
	wire [1:0] strap_w = s2_r[1:0];
	wire permit_n_w = s2_r[2];
	wire single_w = s2_r[3];
	wire [1:0] det_w = s2_r[5:4];
	wire [1:0] done_ev = s2_r[7:6] & ~dn_r;
	wire [5:0] sig_w = s2_r[13:8];
	wire [1:0] oinr_w = s2_r[15:14];
	wire [8:0] avg_w = s2_r[24:16];
	// Two stages of sync latency are waited out before capture
	logic [1:0] tw_r;
	logic [1:0] budget_c_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tw_r <= 2'h0;
			budget_c_r <= 2'h0;
		end else if (tw_r != 2'h3) begin
			tw_r <= tw_r + 2'h1;
			if (tw_r == 2'h2)
				budget_c_r <= strap_w;
		end
	end
	// Register file
	logic [4:0] ctrl_r;
	logic [8:0] pcut_r;
	logic pcut_sw_r;
	logic [4:0] flt_r;
	logic wait_r;
	logic [31:0] rd_r;
	wire req_w = avs_read | avs_write;
	wire acc_w = req_w & ~wait_r;
	wire wr_w = avs_write & acc_w;
	wire wr_ctrl = wr_w & (avs_address == A_CTRL);
	wire wr_pcut = wr_w & (avs_address == A_PCUT);
	wire wr_flt = wr_w & (avs_address == A_FLT);
	wire auto_w = ctrl_r[CB_AUTO];
	wire lim_w = ctrl_r[CB_LIM];
	wire en_w = ctrl_r[CB_EN];
	pci_st_t st_r [2];
	logic [3:0] cls_r [2];
	logic [1:0] typ_r;
	logic [1:0] sfault, cfault, ifault;
	wire [31:0] stat_w = {8'h00, budget_c_r, typ_r, cls_r[1], cls_r[0],
		st_r[1], st_r[0]};
	wire [31:0] rmux_w = (avs_address == A_CTRL) ? {27'h0, ctrl_r}
		: (avs_address == A_STAT) ? stat_w
		: (avs_address == A_PCUT) ? {23'h0, pcut_r}
		: (avs_address == A_FLT) ? {27'h0, flt_r} : 32'h0000_0000;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wait_r <= 1'b1;
			rd_r <= 32'h0000_0000;
		end else begin
			wait_r <= ~(req_w & wait_r);
			if (req_w & wait_r)
				rd_r <= rmux_w;
		end
	end
	assign avs_waitrequest = wait_r;
	assign avs_readdata = rd_r;
	// Highest class across channels drives shared thresholds
	wire [3:0] pclass_w = (cls_r[1] > cls_r[0]) ? cls_r[1] : cls_r[0];
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= CTRL_RST;
			pcut_r <= PCUT_RST;
			pcut_sw_r <= 1'b0;
			flt_r <= FLT_RST;
			port_class <= 4'h0;
		end else begin
			if (wr_ctrl)
				ctrl_r <= avs_writedata[4:0];
			if (wr_pcut) begin
				pcut_r <= avs_writedata[8:0];
				pcut_sw_r <= 1'b1;
			end else if (auto_w && !pcut_sw_r) begin
				pcut_r <= pci_half_w(pclass_w);
			end
			port_class <= pclass_w;
			// Hardware set wins over a same-cycle write-one clear
			flt_r <= (flt_r & ~(wr_flt ? avs_writedata[4:0] : 5'h00))
				| {|ifault, cfault, sfault};
		end
	end
	// Four-pair identification
	wire pwr0_w = (st_r[0] == ST_PWR);
	wire fp_ok = (&det_w) & (single_w | typ_r[0] | pwr0_w);
	wire fp_go = ctrl_r[CB_4P] | (auto_w & ~permit_n_w & fp_ok);
	wire over_pw = pwr0_w && (avg_w > pcut_r);
	// Gate drive comes from its own flop, so the pin never glitches
	logic [1:0] gate_q;
	assign gate_en = gate_q;
	genvar c;
	generate
	for (c = 0; c < 2; c++) begin : g_ch
		logic [2:0] n_r, e1_r, e3_r;
		logic busy_r, rstd_r, inv_r;
		logic [21:0] tm_r;
		wire [2:0] sg = sig_w[3*c+2:3*c];
		wire [2:0] n1 = n_r + 3'h1;
		wire ds = ~single_w;
		wire allow = (c == 0) | fp_go;
		// First and third signatures, counting the event now ending
		wire [2:0] e1n = (n1 == 3'h1) ? sg : e1_r;
		wire [2:0] e3n = (n1 == 3'h3) ? sg : e3_r;
		// Event count needed, given what has been seen so far
		wire full5 = ds & ~lim_w & (pci_cap(budget_c_r, 1'b1) == 4'h5);
		wire [2:0] need = rstd_r ? 3'h1
			: (e1n == 3'h0 || (e1n < 3'h4 && !ds)) ? 3'h1
			: (n1 >= 3'h3 && e3n == 3'h3 && e1n == 3'h4 && full5)
			? 3'h4 : 3'h3;
		wire bt = ds & (e3n == 3'h0 || (e1n == 3'h4 && e3n == 3'h3));
		wire [3:0] raw = rstd_r ? ((e1n > 3'h3) ? 4'h3 : {1'b0, e1n})
			: (n1 == 3'h1 || need == 3'h1) ? {1'b0, e1n}
			: ds ? ((e1n == 3'h4 && e3n == 3'h3 && n1 == 3'h4) ? 4'h5
				: {1'b0, e1n})
			: (e3n == 3'h4) ? 4'h4 : 4'h5 + {1'b0, e3n};
		wire [3:0] cap = pci_cap(budget_c_r, ds);
		wire [3:0] fin = (raw > cap) ? cap : raw;
		wire bad_seq = (n1 == 3'h2 && sg != e1_r)
			|| (n1 == 3'h3 && ds && !(sg == 3'h0 || sg == e1_r
			|| (e1_r == 3'h4 && sg == 3'h3)))
			|| (n1 == 3'h4 && sg != 3'h3) || (sg > 3'h4 && sg != SIG_OVER);
		wire last = done_ev[c] && (n1 >= need);
		wire do_rst = ds & lim_w & ~rstd_r & (fin >= 4'h4);
		wire cut = over_pw;
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				st_r[c] <= ST_IDLE;
				n_r <= 3'h0;
				e1_r <= 3'h0;
				e3_r <= 3'h0;
				busy_r <= 1'b0;
				rstd_r <= 1'b0;
				inv_r <= 1'b0;
				tm_r <= 22'h0;
				cls_r[c] <= 4'h0;
				typ_r[c] <= 1'b0;
				cls_go[c] <= 1'b0;
				cls_hold_low[c] <= 1'b0;
				gate_q[c] <= 1'b0;
				gate_servo[c] <= 1'b0;
				chan_powered[c] <= 1'b0;
				sfault[c] <= 1'b0;
				cfault[c] <= 1'b0;
				ifault[c] <= 1'b0;
			end else begin
				cls_go[c] <= 1'b0;
				sfault[c] <= 1'b0;
				cfault[c] <= 1'b0;
				ifault[c] <= 1'b0;
				gate_servo[c] <= gate_q[c] & oinr_w[c];
				unique case (st_r[c])
				ST_IDLE: begin
					gate_q[c] <= 1'b0;
					chan_powered[c] <= 1'b0;
					n_r <= 3'h0;
					rstd_r <= 1'b0;
					inv_r <= 1'b0;
					if (en_w && (auto_w || (c == 1 && ctrl_r[CB_4P])))
						st_r[c] <= ST_DET;
				end
				ST_DET: begin
					if (!en_w)
						st_r[c] <= ST_IDLE;
					else if (det_w[c] && allow) begin
						if (ctrl_r[CB_CLS])
							st_r[c] <= ST_CLS;
						else begin
							st_r[c] <= ST_INR;
							tm_r <= START_N[21:0];
						end
					end
				end
				ST_CLS: begin
					if (!busy_r) begin
						cls_go[c] <= 1'b1;
						busy_r <= 1'b1;
					end else if (done_ev[c]) begin
						busy_r <= 1'b0;
						n_r <= n1;
						if (n1 == 3'h1)
							e1_r <= sg;
						if (n1 == 3'h3)
							e3_r <= sg;
						if (sg == SIG_OVER || bad_seq)
							inv_r <= 1'b1;
						if (last) begin
							cls_r[c] <= fin;
							typ_r[c] <= bt;
							ifault[c] <= inv_r | (sg == SIG_OVER) | bad_seq;
							if (do_rst) begin
								st_r[c] <= ST_CRST;
								cls_hold_low[c] <= 1'b1;
								tm_r <= CRST_N[21:0];
							end else begin
								st_r[c] <= ST_INR;
								tm_r <= START_N[21:0];
							end
						end
					end
				end
				ST_CRST: begin
					if (tm_r == 22'h1) begin
						cls_hold_low[c] <= 1'b0;
						rstd_r <= 1'b1;
						n_r <= 3'h0;
						st_r[c] <= ST_CLS;
					end
					tm_r <= tm_r - 22'h1;
				end
				ST_INR: begin
					gate_q[c] <= 1'b1;
					tm_r <= tm_r - 22'h1;
					if (cut) begin
						st_r[c] <= ST_IDLE;
						cfault[c] <= 1'b1;
					end else if (tm_r == 22'h1) begin
						if (oinr_w[c]) begin
							st_r[c] <= ST_IDLE;
							sfault[c] <= 1'b1;
							gate_q[c] <= 1'b0;
						end else begin
							st_r[c] <= ST_PWR;
							chan_powered[c] <= 1'b1;
						end
					end
				end
				ST_PWR: begin
					if (cut || !en_w) begin
						st_r[c] <= ST_IDLE;
						cfault[c] <= cut;
						gate_q[c] <= 1'b0;
						chan_powered[c] <= 1'b0;
					end
				end
				default: st_r[c] <= ST_IDLE;
				endcase
			end
		end
		a_start_full: assert property (@(posedge clk) disable iff (sys_rst)
			$rose(gate_q[c]) |-> (st_r[c] == ST_INR) [*8])
			else $error("Inrush left early");
		a_inv_flag: assert property (@(posedge clk) disable iff (sys_rst)
			(st_r[c] == ST_CLS && done_ev[c] && busy_r && last
			&& sg == SIG_OVER) |=> ifault[c])
			else $error("Over signature not flagged");
		a_hold_low: assert property (@(posedge clk) disable iff (sys_rst)
			(st_r[c] == ST_CRST) |-> cls_hold_low[c] || tm_r == 22'h0)
			else $error("Class reset without low hold");
		a_fail_cut: assert property (@(posedge clk) disable iff (sys_rst)
			(st_r[c] == ST_INR && tm_r == 22'h1 && !cut && oinr_w[c])
			|=> st_r[c] == ST_IDLE && sfault[c])
			else $error("Failed inrush not cut");
		a_cls_first: assert property (@(posedge clk) disable iff (sys_rst)
			(st_r[c] == ST_DET && en_w && det_w[c] && allow && ctrl_r[CB_CLS])
			|=> st_r[c] == ST_CLS)
			else $error("Detection not followed by class");
		c_powered: cover property (@(posedge clk) $rose(chan_powered[c]));
		c_crst: cover property (@(posedge clk) $rose(cls_hold_low[c]));
	end
	endgenerate
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			port_current_limit_code <= INR_HI;
		else
			port_current_limit_code <= (fp_go && single_w && pclass_w <= 4'h4)
				? INR_LO : INR_HI;
	end
	a_servo_lim: assert property (@(posedge clk) disable iff (sys_rst)
		(gate_q[0] && oinr_w[0]) |=> gate_servo[0])
		else $error("No servo over inrush limit");
	a_police_cut: assert property (@(posedge clk) disable iff (sys_rst)
		(pwr0_w && avg_w > pcut_r) |=> st_r[0] == ST_IDLE && cfault[0])
		else $error("Power over limit not cut");
	a_ch1_gate: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r[1] == ST_DET && !fp_go) |=> (st_r[1] == ST_DET || st_r[1] == ST_IDLE))
		else $error("Four-pair power without identification");
	c_fault: cover property (@(posedge clk) |flt_r);
endmodule
`default_nettype wire

// >>> shared/pci_pkg.sv
// Constants, states and tables for the class/inrush sequencer
//How it works
//- Classify right after a successful detection
//- Auto mode sets thresholds from class result
//- Each dual-signature pairset classified on its own
//- Three class events for dual-signature class 1-4
//- Power-limited: class reset demotes class 4/5
//- Power-limited: three events demote class 5
//- Four events to class 5 when power allows
//- Four-pair power only when identification allows
//- Report class and type for dual-signature
//- Third event decides the pairset type
//- Class reset holds voltage low, one event
//- Auto: channel count from identification and permit
//- Host may command four-pair power later
//- Over-limit class signature flags invalid result
//- Illegal signature sequence flags invalid result
//- Auto mode runs without host help
//- Power-mode straps sampled at reset set budget
//- Ramp gate of commanded channels only
//- Inrush limit code 08h or 80h
//- Servo gate while current exceeds inrush limit
//- Per-channel start timer, then current check
//- Failed inrush cuts power and sets fault
//- One-second average power over limit cuts port
package pci_pkg;
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_STAT = 4'h4;
	localparam logic [3:0] A_PCUT = 4'h8;
	localparam logic [3:0] A_FLT = 4'hC;
	localparam int CB_CLS = 0;
	localparam int CB_AUTO = 1;
	localparam int CB_LIM = 2;
	localparam int CB_4P = 3;
	localparam int CB_EN = 4;
	localparam logic [4:0] CTRL_RST = 5'h13;
	localparam logic [8:0] PCUT_RST = 9'h100;
	localparam logic [4:0] FLT_RST = 5'h00;
	localparam int CLK_MHZ = 20;
	localparam int START_US = 60000;
	localparam int CRST_US = 10000;
	localparam int START_CYC = START_US * CLK_MHZ;
	localparam int CRST_CYC = CRST_US * CLK_MHZ;
	localparam logic [7:0] INR_LO = 8'h08;
	localparam logic [7:0] INR_HI = 8'h80;
	localparam logic [2:0] SIG_OVER = 3'h7;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01, ST_DET = 6'h02, ST_CLS = 6'h04,
		ST_CRST = 6'h08, ST_INR = 6'h10, ST_PWR = 6'h20
	} pci_st_t;
	// Class power in 0.5 W steps, used for the policing threshold
	function automatic logic [8:0] pci_half_w(input logic [3:0] c);
		case (c)
			4'h1: pci_half_w = 9'h008;
			4'h2: pci_half_w = 9'h00D;
			4'h4: pci_half_w = 9'h033;
			4'h5: pci_half_w = 9'h050;
			4'h6: pci_half_w = 9'h066;
			4'h7: pci_half_w = 9'h07C;
			4'h8: pci_half_w = 9'h08F;
			default: pci_half_w = 9'h01A;
		endcase
	endfunction
	// Highest class the strapped budget grants, single or dual signature
	function automatic logic [3:0] pci_cap(input logic [1:0] b, input logic ds);
		pci_cap = ds ? ((b == 2'h0) ? 4'h3 : (b == 2'h3) ? 4'h5 : 4'h4)
			: (4'h5 + {2'h0, b});
	endfunction
endpackage

// >>> verification/pci_pd_model.sv
// Behavioural powered device answering class events and drawing inrush current
`timescale 1ns/1ps
`default_nettype none
module pci_pd_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [1:0] cls_go,
	input wire logic [1:0] cls_hold_low,
	input wire logic [1:0] gate_en,
	input wire logic [2:0] sig_first,
	input wire logic [2:0] sig_later,
	input wire logic inrush_bad,
	input wire logic [3:0] lag,
	output logic [1:0] cls_done,
	output logic [5:0] cls_sig,
	output logic [1:0] over_inrush
);
	int cnt_r [2];
	int evt_r [2];
	logic [2:0] val_r [2];
	logic tick_r;
	// Overloaded load draws current on every ramping channel
	assign over_inrush = gate_en & {2{inrush_bad}};
	always_ff @(posedge clk or posedge sys_rst) begin
		tick_r <= sys_rst ? 1'b0 : !tick_r;
		for (int c = 0; c < 2; c++) begin
			if (sys_rst || cls_hold_low[c]) begin
				cnt_r[c] <= 0;
				evt_r[c] <= 0;
				val_r[c] <= 3'h0;
			end else if (cls_go[c]) begin
				cnt_r[c] <= 11 + int'(lag);
				val_r[c] <= (evt_r[c] < 2) ? sig_first : sig_later;
				evt_r[c] <= evt_r[c] + 1;
			end else if (cnt_r[c] > 0) begin
				cnt_r[c] <= cnt_r[c] - 1;
			end
		end
	end
	// Signature stands well around the done level; outside it the line wanders
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			cls_done[c] = (cnt_r[c] >= 3) && (cnt_r[c] <= 8);
			cls_sig[c*3+:3] = (cnt_r[c] >= 1 && cnt_r[c] <= 10) ? val_r[c] : {tick_r, !tick_r, tick_r};
		end
	end
endmodule
`default_nettype wire

// >>> verification/pse_class_inrush_sequencer_tb_top.sv
// Self-checking bench for the class and inrush sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
`define WAIT(c, lim) begin wn = 0; while (!(c) && wn < lim) begin wn++; @(posedge clk); end \
	if (wn >= lim) begin n_errors++; $display("[FAIL] wait expected 1 seen 0"); end end
module pse_class_inrush_sequencer_tb_top;
	import pci_pkg::*;
	localparam int START_N = 20;
	typedef struct packed {logic [3:0] a; logic w; logic [31:0] d; logic [31:0] e;} pci_row_t;
	logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, inrush_bad, single_sig;
	logic strap_lo, strap_hi, permit_n;
	logic [3:0] avs_address, port_class, lag;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [1:0] det_ok, cls_done, over_inrush, gate_en, gate_servo, cls_go, hold_low, chan_powered;
	logic [5:0] cls_sig;
	logic [2:0] sig_first, sig_later;
	logic [8:0] avg_power;
	logic [7:0] limit_code;
	int n_errors = 0;
	int num_checks = 0;
	int wn;
	pci_row_t rows [7] = '{{A_CTRL, 1'b0, 32'h0, 32'h0000_0013}, {A_PCUT, 1'b0, 32'h0, 32'h0000_001A},
		{A_FLT, 1'b0, 32'h0, 32'h0}, {4'h2, 1'b1, 32'hFFFF_FFFF, 32'h0}, {4'h2, 1'b0, 32'h0, 32'h0},
		{A_PCUT, 1'b1, 32'h0000_0055, 32'h0}, {A_PCUT, 1'b0, 32'h0, 32'h0000_0055}};
	pci_seq #(.START_N(START_N), .CRST_N(10)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.power_budget_strap_low(strap_lo), .power_budget_strap_high(strap_hi),
		.four_pair_permit_n(permit_n), .single_sig(single_sig), .det_ok(det_ok), .cls_done(cls_done),
		.cls_sig(cls_sig), .over_inrush(over_inrush), .avg_power(avg_power), .gate_en(gate_en),
		.gate_servo(gate_servo), .cls_go(cls_go), .cls_hold_low(hold_low),
		.chan_powered(chan_powered), .port_current_limit_code(limit_code), .port_class(port_class));
	pci_pd_model u_pd (.clk(clk), .sys_rst(sys_rst), .cls_go(cls_go), .cls_hold_low(hold_low),
		.gate_en(gate_en), .sig_first(sig_first), .sig_later(sig_later), .inrush_bad(inrush_bad),
		.lag(lag), .cls_done(cls_done), .cls_sig(cls_sig), .over_inrush(over_inrush));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Request holds until waitrequest is seen low, then one idle edge passes
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			n++;
			@(posedge clk);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) `CHK("bus answer", 1'b0, avs_waitrequest)
		@(posedge clk);
	endtask
	task automatic rst(input logic [1:0] b);
		strap_hi <= b[1];
		strap_lo <= b[0];
		det_ok <= 2'b00;
		sys_rst <= 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("watchdog expired");
		summarize();
	end
	initial begin
		{sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 38'h0};
		{strap_lo, strap_hi, permit_n, single_sig, det_ok, avg_power} = {4'b0010, 11'h0};
		{sig_first, sig_later, inrush_bad, lag} = {3'h3, 3'h3, 1'b0, 4'h1};
		rst(2'b11);
		foreach (rows[i]) begin
			bus(rows[i].a, rows[i].w, rows[i].d);
			if (!rows[i].w) `CHK("register", rows[i].e, q)
		end
		$display("register rows done");
		for (int b = 0; b < 4; b++) begin
			rst(b[1:0]);
			bus(A_STAT, 1'b0, 32'h0);
			`CHK("budget straps", b[1:0], q[23:22])
		end
		$display("strap test done");
		rst(2'b11);
		single_sig <= 1'b1;
		permit_n <= 1'b0;
		det_ok <= 2'b11;
		`WAIT(gate_en !== 2'b00, 400)
		repeat (3) @(posedge clk);
		`CHK("inrush limit code", 8'h08, limit_code)
		`WAIT(chan_powered === 2'b11, 100)
		`CHK("inrush length", START_N - 4, wn)
		`CHK("port class", 4'h3, port_class)
		bus(A_STAT, 1'b0, 32'h0);
		`CHK("powered state", 6'h20, q[5:0])
		bus(A_PCUT, 1'b0, 32'h0);
		`CHK("auto power cut", 32'h0000_001A, q)
		$display("auto power-up done");
		bus(A_PCUT, 1'b1, 32'h0000_0010);
		avg_power <= 9'h011;
		`WAIT(chan_powered === 2'b00, 100)
		det_ok <= 2'b00;
		avg_power <= 9'h000;
		bus(A_FLT, 1'b0, 32'h0);
		`CHK("power cut fault", 1'b1, |q[3:2])
		bus(A_FLT, 1'b1, 32'h0000_001F);
		bus(A_FLT, 1'b0, 32'h0);
		`CHK("fault clear", 32'h0, q)
		$display("policing done");
		rst(2'b11);
		inrush_bad <= 1'b1;
		det_ok <= 2'b11;
		`WAIT(gate_servo !== 2'b00, 400)
		`CHK("gate servo", 1'b1, |gate_servo)
		`WAIT(gate_en === 2'b00, 100)
		det_ok <= 2'b00;
		`CHK("no power after failed inrush", 2'b00, chan_powered)
		bus(A_FLT, 1'b0, 32'h0);
		`CHK("start fault", 1'b1, |q[1:0])
		$display("inrush fault done");
		inrush_bad <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			rst(2'b11);
			single_sig <= (k == 0);
			sig_first <= (k == 0) ? SIG_OVER : 3'h4;
			sig_later <= (k == 0) ? SIG_OVER : 3'h2;
			lag <= 4'h6;
			det_ok <= 2'b11;
			repeat (300) @(posedge clk);
			det_ok <= 2'b00;
			bus(A_FLT, 1'b0, 32'h0);
			`CHK("invalid class", 1'b1, q[4])
		end
		$display("invalid class done");
		// Full four-event class 5, then power-limited class reset to 13 W
		for (int k = 0; k < 2; k++) begin
			rst(2'b11);
			single_sig <= 1'b0;
			permit_n <= 1'b0;
			lag <= 4'h1;
			if (k == 1)
				bus(A_CTRL, 1'b1, 32'h0000_0017);
			sig_first <= 3'h4;
			sig_later <= (k == 0) ? 3'h3 : 3'h0;
			det_ok <= 2'b11;
			`WAIT(chan_powered === 2'b11, 900)
			`CHK("dual class", (k == 0) ? 4'h5 : 4'h3, port_class)
			bus(A_STAT, 1'b0, 32'h0);
			`CHK("dual type", 2'b11, q[21:20])
		end
		$display("dual signature done");
		// Legacy pairsets without permit: one channel, then host asks for four pairs
		rst(2'b11);
		permit_n <= 1'b1;
		sig_first <= 3'h2;
		sig_later <= 3'h2;
		det_ok <= 2'b11;
		`WAIT(chan_powered[0] === 1'b1, 900)
		repeat (100) @(posedge clk);
		`CHK("one pairset only", 2'b01, chan_powered)
		bus(A_CTRL, 1'b1, 32'h0000_001B);
		`WAIT(chan_powered === 2'b11, 900)
		`CHK("host four-pair", 2'b11, chan_powered)
		`CHK("dual inrush limit code", 8'h80, limit_code)
		$display("four-pair command done");
		summarize();
	end
endmodule
`default_nettype wire
